//--- eac_access_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Write starts only with master enable armed
// - Late strobe: master enable expired, no write
// - No write while self-program busy
// - Write strobe clears when write time ends
// - Write strobe stalls CPU two cycles
// - Read strobe loads data register at once
// - Read stalls CPU four cycles
// - During write: reads refused, address locked
// - Write timed by 8448 cycles of 1 MHz
// - Write completes through power-down
// - Write completes through reset
// - Master enable self-clears after four cycles
// - Ready interrupt level while write strobe clear
// - 512 bytes, 9-bit address, upper bits zero
module eac_access_ctrl #(
    parameter int NV_DEPTH = eac_pkg::NV_DEPTH,
    parameter int OSC_DIV = eac_pkg::OSC_DIV_DEFAULT,
    parameter int WRITE_CYCLES = eac_pkg::WRITE_OSC_CYCLES
) (
    // Clock and resets
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_por_b,
    // I/O register port
    input wire logic [1:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    input wire logic [7:0] i_io_wdata,
    output logic [7:0] o_io_rdata,
    // System status
    input wire logic i_self_program_busy,
    input wire logic i_global_irq_en,
    input wire logic i_power_down,
    // Outputs
    output logic o_cpu_stall,
    output logic o_ready_irq,
    output logic o_osc_run
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] data;
        logic mwe;
        logic [2:0] mwe_cnt;
        logic wstrobe;
        logic irq_en;
        logic [2:0] stall;
        logic stalled;
        logic [7:0] rdata;
        logic irq;
        logic osc;
        logic [8:0] waddr;
        logic [7:0] wdata;
    } eac_ctl_t;
    eac_ctl_t s_reg, s_next;
    logic [7:0] mem [NV_DEPTH];
    logic tmr_busy;
    logic tmr_done;
    logic start_write;
    logic [7:0] ctl_val;

    eac_osc_timer #(
        .OSC_DIV(OSC_DIV),
        .WRITE_CYCLES(WRITE_CYCLES)
    ) u_timer (
        .i_clk_sys(i_clk_sys),
        .i_por_b(i_por_b),
        .i_start(start_write),
        .o_busy(tmr_busy),
        .o_done(tmr_done)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_next = s_reg;
        start_write = 1'b0;
        ctl_val = {4'h0, s_next.irq_en, s_next.mwe, s_next.wstrobe, 1'b0};
        if (s_reg.stall != 3'h0) begin
            s_next.stall = s_reg.stall - 3'h1;
        end
        if (s_reg.mwe) begin
            if (s_reg.mwe_cnt == 3'(eac_pkg::MASTER_WE_CYCLES - 1)) begin
                s_next.mwe = 1'b0;
            end else begin
                s_next.mwe_cnt = s_reg.mwe_cnt + 3'h1;
            end
        end
        if (tmr_done) begin
            s_next.wstrobe = 1'b0;
        end
        // No access is taken while reset holds the registers
        if (i_io_wr && i_rst_b && s_reg.stall == 3'h0) begin
            case (i_io_addr)
                eac_pkg::ADDR_CONTROL: begin
                    s_next.irq_en = i_io_wdata[eac_pkg::BIT_READY_IRQ_EN];
                    if (i_io_wdata[eac_pkg::BIT_MASTER_WE]) begin
                        s_next.mwe = 1'b1;
                        s_next.mwe_cnt = 3'h0;
                    end
                    if (i_io_wdata[eac_pkg::BIT_WRITE_STROBE] && s_reg.mwe
                        && !tmr_busy && !s_reg.wstrobe
                        && !i_self_program_busy) begin
                        start_write = 1'b1;
                        s_next.wstrobe = 1'b1;
                        s_next.mwe = 1'b0;
                        s_next.waddr = s_reg.addr;
                        s_next.wdata = s_reg.data;
                        s_next.stall = 3'(eac_pkg::WRITE_STALL_CYCLES);
                    end else if (i_io_wdata[eac_pkg::BIT_READ_STROBE]
                        && !tmr_busy && !s_reg.wstrobe) begin
                        s_next.data = mem[s_reg.addr];
                        s_next.stall = 3'(eac_pkg::READ_STALL_CYCLES);
                    end
                end
                eac_pkg::ADDR_DATA: begin
                    s_next.data = i_io_wdata;
                end
                eac_pkg::ADDR_ADDR_LO: begin
                    if (!s_reg.wstrobe) begin
                        s_next.addr[7:0] = i_io_wdata;
                    end
                end
                eac_pkg::ADDR_ADDR_HI: begin
                    if (!s_reg.wstrobe) begin
                        s_next.addr[8] = i_io_wdata[0];
                    end
                end
                default: begin
                end
            endcase
        end
        ctl_val = {4'h0, s_next.irq_en, s_next.mwe, s_next.wstrobe, 1'b0};
        case (i_io_addr)
            eac_pkg::ADDR_CONTROL: s_next.rdata = ctl_val;
            eac_pkg::ADDR_DATA: s_next.rdata = s_next.data;
            eac_pkg::ADDR_ADDR_LO: s_next.rdata = s_next.addr[7:0];
            eac_pkg::ADDR_ADDR_HI: s_next.rdata = {7'h00, s_next.addr[8]};
            default: s_next.rdata = 8'h00;
        endcase
        s_next.irq = s_next.irq_en && i_global_irq_en
            && !s_next.wstrobe;
        // Once running, oscillator stays on while asleep
        s_next.osc = tmr_busy || start_write
            || (s_reg.osc && i_power_down);
        s_next.stalled = s_next.stall != 3'h0;
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            s_reg <= '0;
            // Write in flight survives reset
            s_reg.wstrobe <= tmr_busy && !tmr_done;
            s_reg.waddr <= s_reg.waddr;
            s_reg.wdata <= s_reg.wdata;
            s_reg.osc <= tmr_busy || (s_reg.osc && i_power_down);
        end else begin
            s_reg <= s_next;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (tmr_done) begin
            mem[s_reg.waddr] <= s_reg.wdata;
        end
    end

    assign o_io_rdata = s_reg.rdata;
    assign o_cpu_stall = s_reg.stalled;
    assign o_ready_irq = s_reg.irq;
    assign o_osc_run = s_reg.osc;

    // ************************************************************
    // Checks
    // ************************************************************
    a_mwe_expire: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        $rose(s_reg.mwe) |-> ##[1:4] !s_reg.mwe)
        else $error("master enable did not expire");
    a_write_gate: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        $rose(s_reg.wstrobe) |->
        $past(s_reg.mwe) && !$past(i_self_program_busy))
        else $error("write started without arming");
    a_write_stall: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        start_write |=> o_cpu_stall [*2] ##1 !o_cpu_stall)
        else $error("write stall not two cycles");
    a_read_stall: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (s_reg.stall == 3'h0 && s_next.stall == 3'h4) |=>
        o_cpu_stall [*4] ##1 !o_cpu_stall)
        else $error("read stall not four cycles");
    a_done_clears: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        tmr_done |=> !s_reg.wstrobe)
        else $error("write strobe not cleared");
    // First edge after a reset is skipped: reset may clear the address
    a_addr_locked: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        s_reg.wstrobe && $past(s_reg.wstrobe) && $past(i_rst_b)
        |-> $stable(s_reg.addr))
        else $error("address changed during write");
    a_irq_level: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        $past(i_rst_b) |-> o_ready_irq == (s_reg.irq_en
        && $past(i_global_irq_en) && !s_reg.wstrobe))
        else $error("ready interrupt wrong");
    a_osc_busy: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        s_reg.wstrobe |-> o_osc_run)
        else $error("oscillator not running");
    a_addr_hi_zero: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_io_addr == eac_pkg::ADDR_ADDR_HI) |=> o_io_rdata[7:1] == 7'h00)
        else $error("upper address bits not zero");
endmodule

//--- eac_osc_timer.sv
`timescale 1ns/1ps
// ************************************************************
// Self-timed write counter on a 1 MHz tick
// ************************************************************
module eac_osc_timer #(
    parameter int OSC_DIV = eac_pkg::OSC_DIV_DEFAULT,
    parameter int WRITE_CYCLES = eac_pkg::WRITE_OSC_CYCLES
) (
    // Clock and power-on reset
    input wire logic i_clk_sys,
    input wire logic i_por_b,
    // Control
    input wire logic i_start,
    output logic o_busy,
    output logic o_done
);
    typedef struct packed {
        logic [15:0] div;
        logic [15:0] cnt;
        logic busy;
        logic done;
    } eac_tmr_t;
    eac_tmr_t s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        if (i_start && !s_reg.busy) begin
            s_next.busy = 1'b1;
            s_next.div = 16'h0000;
            s_next.cnt = 16'h0000;
        end else if (s_reg.busy) begin
            if (s_reg.div == 16'(OSC_DIV - 1)) begin
                s_next.div = 16'h0000;
                if (s_reg.cnt == 16'(WRITE_CYCLES - 1)) begin
                    s_next.busy = 1'b0;
                    s_next.done = 1'b1;
                end else begin
                    s_next.cnt = s_reg.cnt + 16'h0001;
                end
            end else begin
                s_next.div = s_reg.div + 16'h0001;
            end
        end
    end

    // Only power-on clears it; system reset does not stop a write
    always_ff @(posedge i_clk_sys) begin
        if (!i_por_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_busy = s_reg.busy;
    assign o_done = s_reg.done;
endmodule

//--- eac_pkg.sv
package eac_pkg;
    // ************************************************************
    // Register file
    // ************************************************************
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_DATA = 2'h1;
    localparam logic [1:0] ADDR_ADDR_LO = 2'h2;
    localparam logic [1:0] ADDR_ADDR_HI = 2'h3;
    localparam int BIT_READ_STROBE = 0;
    localparam int BIT_WRITE_STROBE = 1;
    localparam int BIT_MASTER_WE = 2;
    localparam int BIT_READY_IRQ_EN = 3;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam int NV_DEPTH = 512;
    localparam int NV_ADDR_W = 9;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int MASTER_WE_CYCLES = 4;
    localparam int WRITE_STALL_CYCLES = 2;
    localparam int READ_STALL_CYCLES = 4;
    localparam int WRITE_OSC_CYCLES = 8448;
    localparam int WRITE_TIME_US = 8448;
    localparam int OSC_FREQ_MHZ = 1;
    localparam int OSC_DIV_DEFAULT = 100 / OSC_FREQ_MHZ;
    typedef enum logic [1:0] {
        EAC_IDLE,
        EAC_READ,
        EAC_WRITE
    } eac_state_t;
endpackage

//--- tb_eeprom_access_control.sv
`timescale 1ns/1ps
module tb_eeprom_access_control;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic por_b = 1'b0;
    logic [1:0] addr = 2'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic spm = 1'b0;
    logic gie = 1'b0;
    logic pdn = 1'b0;
    logic [7:0] rdata;
    logic stall;
    logic irq;
    logic osc;
    logic [7:0] v;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n;

    always #5 clk = ~clk;

    eac_access_ctrl #(.OSC_DIV(2), .WRITE_CYCLES(4)) u_dut (
        .i_clk_sys(clk), .i_rst_b(rst_b), .i_por_b(por_b),
        .i_io_addr(addr), .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wdata),
        .o_io_rdata(rdata), .i_self_program_busy(spm),
        .i_global_irq_en(gie), .i_power_down(pdn), .o_cpu_stall(stall),
        .o_ready_irq(irq), .o_osc_run(osc));

    // ************************************************************
    // Bus tasks
    // ************************************************************
    task automatic chk(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic idle_slot();
        @(posedge clk);
        #1;
        while (stall !== 1'b0) begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic io_wr(input logic [1:0] a, input logic [7:0] d);
        idle_slot();
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk);
        #1;
        wr = 1'b0;
    endtask

    task automatic io_rd(input logic [1:0] a, output logic [7:0] d);
        idle_slot();
        addr = a;
        rd = 1'b1;
        @(posedge clk);
        #1;
        rd = 1'b0;
        d = rdata;
    endtask

    task automatic stall_len(output int k);
        k = 0;
        while (stall === 1'b1 && k < 20) begin
            k++;
            @(posedge clk);
            #1;
        end
    endtask

    task automatic set_addr(input logic [8:0] a);
        io_wr(eac_pkg::ADDR_ADDR_LO, a[7:0]);
        io_wr(eac_pkg::ADDR_ADDR_HI, {7'h00, a[8]});
    endtask

    task automatic start_write(input logic [8:0] a, input logic [7:0] d);
        set_addr(a);
        io_wr(eac_pkg::ADDR_DATA, d);
        io_wr(eac_pkg::ADDR_CONTROL, 8'h0c);
        io_wr(eac_pkg::ADDR_CONTROL, 8'h0a);
    endtask

    task automatic wait_idle();
        int k;
        k = 0;
        v = 8'h02;
        while (v[1] !== 1'b0 && k < 100) begin
            io_rd(eac_pkg::ADDR_CONTROL, v);
            k++;
        end
        chk("write strobe done", v & 8'h02, 8'h00);
    endtask

    task automatic read_byte(input logic [8:0] a, output logic [7:0] d);
        set_addr(a);
        // Clear data first so a missed read shows
        io_wr(eac_pkg::ADDR_DATA, 8'h00);
        io_wr(eac_pkg::ADDR_CONTROL, 8'h09);
        stall_len(n);
        chk("read stall", 8'(n), 8'(eac_pkg::READ_STALL_CYCLES));
        io_rd(eac_pkg::ADDR_DATA, d);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset_and_width();
        io_rd(eac_pkg::ADDR_CONTROL, v);
        chk("control reset", v, eac_pkg::CONTROL_RESET);
        io_wr(eac_pkg::ADDR_ADDR_HI, 8'hff);
        io_rd(eac_pkg::ADDR_ADDR_HI, v);
        chk("address high", v, 8'h01);
    endtask

    task automatic t_unarmed_and_late();
        io_wr(eac_pkg::ADDR_CONTROL, 8'h02);
        io_rd(eac_pkg::ADDR_CONTROL, v);
        chk("unarmed strobe", v, 8'h00);
        io_wr(eac_pkg::ADDR_CONTROL, 8'h04);
        io_rd(eac_pkg::ADDR_CONTROL, v);
        chk("master enable set", v, 8'h04);
        @(posedge clk);
        io_wr(eac_pkg::ADDR_CONTROL, 8'h02);
        io_rd(eac_pkg::ADDR_CONTROL, v);
        chk("late strobe", v, 8'h00);
        io_wr(eac_pkg::ADDR_CONTROL, 8'h04);
        repeat (2) @(posedge clk);
        io_wr(eac_pkg::ADDR_CONTROL, 8'h02);
        io_rd(eac_pkg::ADDR_CONTROL, v);
        chk("last slot strobe", v & 8'h02, 8'h02);
        wait_idle();
    endtask

    task automatic t_write_read();
        io_wr(eac_pkg::ADDR_CONTROL, 8'h08);
        io_rd(eac_pkg::ADDR_CONTROL, v);
        chk("ready irq masked", {7'h00, irq}, 8'h00);
        gie = 1'b1;
        io_rd(eac_pkg::ADDR_CONTROL, v);
        chk("ready irq idle", {7'h00, irq}, 8'h01);
        pdn = 1'b1;
        start_write(9'h1a5, 8'h3c);
        stall_len(n);
        chk("write stall", 8'(n), 8'(eac_pkg::WRITE_STALL_CYCLES));
        chk("osc in sleep", {7'h00, osc}, 8'h01);
        chk("ready irq busy", {7'h00, irq}, 8'h00);
        io_rd(eac_pkg::ADDR_CONTROL, v);
        chk("write busy", v & 8'h02, 8'h02);
        io_wr(eac_pkg::ADDR_ADDR_LO, 8'h00);
        io_wr(eac_pkg::ADDR_CONTROL, 8'h09);
        wait_idle();
        chk("osc kept in sleep", {7'h00, osc}, 8'h01);
        chk("ready irq back", {7'h00, irq}, 8'h01);
        pdn = 1'b0;
        io_rd(eac_pkg::ADDR_ADDR_LO, v);
        chk("address locked", v, 8'ha5);
        io_rd(eac_pkg::ADDR_DATA, v);
        chk("read refused", v, 8'h3c);
        chk("osc stopped", {7'h00, osc}, 8'h00);
        read_byte(9'h1a5, v);
        chk("read back", v, 8'h3c);
        io_rd(eac_pkg::ADDR_CONTROL, v);
        chk("read strobe clear", v, 8'h08);
    endtask

    task automatic t_reset_mid_write();
        start_write(9'h0f0, 8'hc3);
        rst_b = 1'b0;
        @(posedge clk);
        #1;
        rst_b = 1'b1;
        chk("osc through reset", {7'h00, osc}, 8'h01);
        io_rd(eac_pkg::ADDR_CONTROL, v);
        chk("write kept", v & 8'h02, 8'h02);
        wait_idle();
        read_byte(9'h0f0, v);
        chk("write survived", v, 8'hc3);
    endtask

    task automatic t_self_program_busy();
        spm = 1'b1;
        start_write(9'h010, 8'h77);
        chk("no osc", {7'h00, osc}, 8'h00);
        io_rd(eac_pkg::ADDR_CONTROL, v);
        chk("spm blocks", v & 8'h02, 8'h00);
        spm = 1'b0;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            results();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'b1;
        por_b = 1'b1;
        t_reset_and_width();
        t_unarmed_and_late();
        t_write_read();
        t_reset_mid_write();
        t_self_program_busy();
        results();
    end
endmodule
